// ---- src/uart_channel_irq.sv ----
// per-channel interrupt sources, priority encoder and apb register slave
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

// What this block does
// (RULE1) fifo mode: receive interrupt while rx level at or above trigger
// (RULE2) data-ready sets on a character entering the fifo, clears when empty
// (RULE3) host polls line-state with fifos on and mask bits 3:0 clear
// (RULE4) line-state shows overrun, top byte errors, tx empties, fifo error
// (RULE5) mask bit 7 interrupts on input flow pin rising; bits 7:5 need gate
// (RULE6) mask bit 6 interrupts on own output flow pin rising
// (RULE7) mask bit 5 enables the received xoff interrupt
// (RULE8) mask bit 3 interrupts on any modem-state change flag
// (RULE9) line interrupt on errored receive, again when it reaches the top
// (RULE10) errored byte behind clean top shows only fifo error bit 7
// (RULE11) tx interrupt: non-fifo on empty, fifo below trigger and empty
// (RULE12) auto rs-485 delays the second tx interrupt to shifter empty
// (RULE13) non-fifo: receive interrupt while holding register has a char
// (RULE14) time-out after four chars plus twelve bits, cleared by rx read
// (RULE15) flow pin interrupts only in auto flow, cleared by modem read
// (RULE16) wake-up shows code none, cleared by global source read
// (RULE17) line read clears line interrupt; rx clears below trigger
// (RULE18) cause read or tx write clears tx; modem read clears modem
// (RULE19) cause read clears xon/xoff; special also clears on next char
// (RULE20) cause codes per priority one to seven, 0x01 for none
// (RULE21) cause shows only highest pending source; others stay queued
// (RULE22) cause bits 7:6 read one with fifos enabled, else zero
// (RULE23) sources appear in cause register and encoded global output
// (RULE24) rx trigger from config bits 7:6 selects 8, 16, 24 or 28
// (RULE25) channel request high while any enabled source pending
module uart_channel_irq (
  input  wire logic                        sys_clk_in,
  input  wire logic                        rst_in,
  input  wire logic                        psel_in,
  input  wire logic                        penable_in,
  input  wire logic                        pwrite_in,
  input  wire logic [7:0]                  paddr_in,
  input  wire logic [31:0]                 pwdata_in,
  output logic      [31:0]                 prdata_out,
  output logic                             pready_out,
  output logic                             pslverr_out,
  input  wire logic                        bit_tick_in,
  input  wire logic [1:0]                  flow_pin_in,
  input  wire uart_irq_pkg::chan_status_t  status_in,
  input  wire uart_irq_pkg::host_strobe_t  strobe_in,
  output logic                             irq_out,
  output logic      [2:0]                  irq_level_out,
  output logic                             wake_out
);
  import uart_irq_pkg::*;

  logic [7:0]  interrupt_mask_reg;
  logic [12:0] config_reg;
  logic [7:0]  interrupt_cause_reg;
  logic [7:0]  cause_shown_reg;
  logic [7:0]  line_state_reg;
  logic [7:0]  modem_state_reg;
  logic [31:0] rdata_next;
  logic        err_next;
  logic [1:0]  pin_s1_reg;
  logic [1:0]  pin_s2_reg;
  logic [1:0]  pin_s3_reg;
  logic [1:0]  pin_level_reg;
  logic [1:0]  out_prev_reg;
  logic        data_ready_reg;
  logic        line_flag_reg;
  logic        tmo_flag_reg;
  logic        tx_flag_reg;
  logic        modem_flag_reg;
  logic        xchar_flag_reg;
  logic        special_reg;
  logic        flow_flag_reg;
  logic        wake_reg;
  logic [2:0]  top_err_prev_reg;
  logic        tx_below_prev_reg;
  logic        tx_done_prev_reg;
  logic [6:0]  tmo_cnt_reg;
  logic [5:0]  cause_next;
  logic [2:0]  level_next;
  logic        setup_phase;
  logic        access_done;
  logic        rd_cause;
  logic        rd_line;
  logic        rd_modem;
  logic        fifo_en;
  logic        gate;
  logic [7:0]  eff_mask;
  logic [5:0]  rx_trig;
  logic [5:0]  tx_trig;
  logic        rx_irq_lvl;
  logic        tx_below;
  logic        tx_done;
  logic        tx_event;
  logic        in_pin;
  logic        in_prev;
  logic        out_pin;
  logic        out_prev;
  logic        flow_event;

  assign fifo_en  = config_reg[CFG_FIFO_EN];
  assign gate     = config_reg[CFG_GATE];
  // enhanced mask bits are dead unless the feature gate is open
  assign eff_mask = {interrupt_mask_reg[7:5] & {3{gate}}, 1'b0, interrupt_mask_reg[3:0]}; // RULE5

  // apb: zero wait states, answer prepared during the setup cycle
  assign setup_phase = psel_in & ~penable_in;
  assign access_done = psel_in & penable_in & pready_out;
  assign rd_cause = access_done & ~pwrite_in & (paddr_in == CAUSE_OFS) & ~pslverr_out;
  assign rd_line  = access_done & ~pwrite_in & (paddr_in == LINE_OFS) & ~pslverr_out;
  assign rd_modem = access_done & ~pwrite_in & (paddr_in == MODEM_OFS) & ~pslverr_out;

  // trigger table; tx selection needs the feature gate
  always_comb begin
    case (config_reg[CFG_RX_TRIG +: 2]) // RULE24
      2'd0:    rx_trig = RX_TRIG_0;
      2'd1:    rx_trig = RX_TRIG_1;
      2'd2:    rx_trig = RX_TRIG_2;
      default: rx_trig = RX_TRIG_3;
    endcase
    case (gate ? config_reg[CFG_TX_TRIG +: 2] : 2'd0)
      2'd0:    tx_trig = TX_TRIG_0;
      2'd1:    tx_trig = TX_TRIG_1;
      2'd2:    tx_trig = TX_TRIG_2;
      default: tx_trig = TX_TRIG_3;
    endcase
  end

  // receive data: level in fifo mode, any char in non-fifo mode
  assign rx_irq_lvl = fifo_en ? (status_in.rx_level >= rx_trig) // RULE1
                              : (status_in.rx_level != 6'd0);   // RULE13

  // transmit events: one edge in non-fifo mode, two in fifo mode
  assign tx_below = fifo_en ? (status_in.tx_level < tx_trig) : 1'b0; // RULE11
  assign tx_done  = (status_in.tx_level == 6'd0) &
                    (~config_reg[CFG_RS485] | status_in.tx_shift_empty); // RULE12
  assign tx_event = (tx_below & ~tx_below_prev_reg) | (tx_done & ~tx_done_prev_reg); // RULE11

  // flow pin pair picked by the modem-control select bit
  assign in_pin     = pin_level_reg[config_reg[CFG_FLOW_SEL]];
  assign in_prev    = out_prev_reg[0];
  assign out_pin    = status_in.flow_out[config_reg[CFG_FLOW_SEL]];
  assign out_prev   = out_prev_reg[1];
  assign flow_event = (in_pin & ~in_prev & eff_mask[MSK_INP] & config_reg[CFG_AUTO_IN]) | // RULE5
                      (out_pin & ~out_prev & eff_mask[MSK_OUTP]
                       & config_reg[CFG_AUTO_OUT]); // RULE6

  // three-stage pin synchroniser; level moves once stages two and three agree
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pin_s1_reg    <= 2'h0;
      pin_s2_reg    <= 2'h0;
      pin_s3_reg    <= 2'h0;
      pin_level_reg <= 2'h0;
    end else begin
      pin_s1_reg <= flow_pin_in;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      for (int i = 0; i < 2; i++) begin
        if (pin_s2_reg[i] == pin_s3_reg[i]) begin
          pin_level_reg[i] <= pin_s3_reg[i];
        end
      end
    end
  end

  // edge history
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      out_prev_reg      <= 2'h0;
      top_err_prev_reg  <= 3'h0;
      tx_below_prev_reg <= 1'b0;
      tx_done_prev_reg  <= 1'b1;
    end else begin
      out_prev_reg      <= {out_pin, in_pin};
      top_err_prev_reg  <= status_in.top_err;
      tx_below_prev_reg <= tx_below;
      tx_done_prev_reg  <= tx_done;
    end
  end

  // control registers written over apb
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      interrupt_mask_reg <= MASK_RST;
      config_reg         <= CONFIG_RST;
    end else if (access_done & pwrite_in) begin
      if (paddr_in == MASK_OFS) begin
        // bit 4 reserved, upper bits only take with the gate open
        interrupt_mask_reg <= {gate ? pwdata_in[7:5] : interrupt_mask_reg[7:5],
                               1'b0, pwdata_in[3:0]}; // RULE5
      end
      if (paddr_in == CONFIG_OFS) begin
        config_reg <= pwdata_in[12:0];
      end
    end
  end

  // data ready: set wins over the empty clear
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      data_ready_reg <= 1'b0;
    end else if (status_in.rx_push) begin
      data_ready_reg <= 1'b1; // RULE2
    end else if (status_in.rx_level == 6'd0) begin
      data_ready_reg <= 1'b0; // RULE2
    end
  end

  // line status: on errored arrival and again when an error reaches the top
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      line_flag_reg <= 1'b0;
    end else if (status_in.rx_push_err | (|(status_in.top_err & ~top_err_prev_reg))) begin
      line_flag_reg <= 1'b1; // RULE9
    end else if (rd_line) begin
      line_flag_reg <= 1'b0; // RULE17
    end
  end

  // receive time-out counts bit ticks while data waits untouched
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      tmo_cnt_reg  <= 7'h00;
      tmo_flag_reg <= 1'b0;
    end else begin
      if (status_in.rx_push | status_in.rx_pop | (status_in.rx_level == 6'd0)) begin
        tmo_cnt_reg <= 7'h00;
      end else if (bit_tick_in & (tmo_cnt_reg != TMO_BITS)) begin
        tmo_cnt_reg <= tmo_cnt_reg + 7'h01;
      end
      if (bit_tick_in & (tmo_cnt_reg == TMO_BITS - 7'h01) & ~status_in.rx_push
          & ~status_in.rx_pop & (status_in.rx_level != 6'd0)) begin
        tmo_flag_reg <= 1'b1; // RULE14
      end else if (strobe_in.rx_holding_read) begin
        tmo_flag_reg <= 1'b0; // RULE14
      end
    end
  end

  // transmit ready: cleared by tx write, or by a cause read that showed it
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      tx_flag_reg <= 1'b0;
    end else if (tx_event) begin
      tx_flag_reg <= 1'b1; // RULE11
    end else if (strobe_in.tx_holding_write
                 | (rd_cause & (cause_shown_reg[5:0] == CODE_TX))) begin
      tx_flag_reg <= 1'b0; // RULE18
    end
  end

  // modem change and flow pin change both clear on a modem-state read
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      modem_flag_reg <= 1'b0;
      flow_flag_reg  <= 1'b0;
    end else begin
      if (status_in.delta_set) begin
        modem_flag_reg <= 1'b1; // RULE8
      end else if (rd_modem) begin
        modem_flag_reg <= 1'b0; // RULE18
      end
      if (flow_event) begin
        flow_flag_reg <= 1'b1; // RULE15
      end else if (rd_modem) begin
        flow_flag_reg <= 1'b0; // RULE15
      end
    end
  end

  // xon/xoff/special: the special kind also clears on the next character
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      xchar_flag_reg <= 1'b0;
      special_reg    <= 1'b0;
    end else if ((status_in.xoff_det | status_in.xon_det | status_in.special_det)
                 & eff_mask[MSK_XOFF]) begin
      xchar_flag_reg <= 1'b1; // RULE7
      special_reg    <= status_in.special_det;
    end else if ((rd_cause & (cause_shown_reg[5:0] == CODE_XCHAR))
                 | (special_reg & status_in.rx_push)) begin
      xchar_flag_reg <= 1'b0; // RULE19
      special_reg    <= 1'b0;
    end
  end

  // wake-up indication
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wake_reg <= 1'b0;
    end else if (status_in.wake) begin
      wake_reg <= 1'b1; // RULE16
    end else if (strobe_in.global_first_read) begin
      wake_reg <= 1'b0; // RULE16
    end
  end

  // priority encoder: only the highest enabled source is shown
  always_comb begin
    cause_next = CODE_NONE; // RULE16
    level_next = 3'd0;
    if (line_flag_reg & eff_mask[MSK_LINE]) begin
      cause_next = CODE_LINE; // RULE20
      level_next = 3'd1;
    end else if (rx_irq_lvl & eff_mask[MSK_RX]) begin
      cause_next = CODE_RX;
      level_next = 3'd2;
    end else if (tmo_flag_reg & eff_mask[MSK_RX]) begin
      cause_next = CODE_TMO;
      level_next = 3'd3;
    end else if (tx_flag_reg & eff_mask[MSK_TX]) begin
      cause_next = CODE_TX;
      level_next = 3'd4;
    end else if (modem_flag_reg & eff_mask[MSK_MODEM]) begin
      cause_next = CODE_MODEM;
      level_next = 3'd5;
    end else if (xchar_flag_reg) begin
      cause_next = CODE_XCHAR;
      level_next = 3'd6;
    end else if (flow_flag_reg) begin
      cause_next = CODE_FLOW;
      level_next = 3'd7;
    end
  end

  // status registers and outputs
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      interrupt_cause_reg <= {2'b00, CODE_NONE};
      line_state_reg      <= 8'h60;
      modem_state_reg     <= 8'h00;
      irq_out             <= 1'b0;
      irq_level_out       <= 3'd0;
      wake_out            <= 1'b0;
    end else begin
      interrupt_cause_reg <= {{2{fifo_en}}, cause_next}; // RULE22
      line_state_reg      <= {status_in.fifo_err_any,                   // RULE10
                              tx_done & status_in.tx_shift_empty,       // RULE4
                              status_in.tx_level == 6'd0,
                              status_in.top_err,                        // RULE10
                              status_in.overrun,
                              data_ready_reg};
      modem_state_reg     <= status_in.modem_bits;
      irq_out             <= (level_next != 3'd0); // RULE25
      irq_level_out       <= level_next;           // RULE23
      wake_out            <= wake_reg;
    end
  end

  // read mux for the setup cycle
  always_comb begin
    rdata_next = 32'h0000_0000;
    err_next   = 1'b0;
    case (paddr_in)
      MASK_OFS:   rdata_next[7:0]  = interrupt_mask_reg;
      CAUSE_OFS:  rdata_next[7:0]  = interrupt_cause_reg; // RULE21
      LINE_OFS:   rdata_next[7:0]  = line_state_reg;      // RULE4
      MODEM_OFS:  rdata_next[7:0]  = modem_state_reg;
      CONFIG_OFS: rdata_next[12:0] = config_reg;
      default:    err_next         = 1'b1;
    endcase
  end

  // apb answer registers; cause seen by the host is frozen for its clear
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      prdata_out      <= 32'h0000_0000;
      pready_out      <= 1'b0;
      pslverr_out     <= 1'b0;
      cause_shown_reg <= {2'b00, CODE_NONE};
    end else if (setup_phase) begin
      prdata_out      <= pwrite_in ? 32'h0000_0000 : rdata_next;
      pready_out      <= 1'b1;
      pslverr_out     <= err_next;
      cause_shown_reg <= interrupt_cause_reg; // RULE21
    end else begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

endmodule // uart_channel_irq

// ---- src/uart_irq_pkg.sv ----
// constants and carrier types for the per-channel interrupt logic
package uart_irq_pkg;

  // apb byte offsets of the channel registers
  localparam logic [7:0] MASK_OFS   = 8'h00;
  localparam logic [7:0] CAUSE_OFS  = 8'h04;
  localparam logic [7:0] LINE_OFS   = 8'h08;
  localparam logic [7:0] MODEM_OFS  = 8'h0C;
  localparam logic [7:0] CONFIG_OFS = 8'h10;

  // reset values
  localparam logic [7:0]  MASK_RST   = 8'h00;
  localparam logic [12:0] CONFIG_RST = 13'h0000;

  // config register field positions
  localparam int CFG_FIFO_EN  = 0;
  localparam int CFG_TX_TRIG  = 4;
  localparam int CFG_RX_TRIG  = 6;
  localparam int CFG_RS485    = 8;
  localparam int CFG_FLOW_SEL = 9;
  localparam int CFG_GATE     = 10;
  localparam int CFG_AUTO_OUT = 11;
  localparam int CFG_AUTO_IN  = 12;

  // mask register bit positions
  localparam int MSK_RX    = 0;
  localparam int MSK_TX    = 1;
  localparam int MSK_LINE  = 2;
  localparam int MSK_MODEM = 3;
  localparam int MSK_XOFF  = 5;
  localparam int MSK_OUTP  = 6;
  localparam int MSK_INP   = 7;

  // cause codes in bits 5:0
  localparam logic [5:0] CODE_LINE  = 6'h06;
  localparam logic [5:0] CODE_RX    = 6'h04;
  localparam logic [5:0] CODE_TMO   = 6'h0C;
  localparam logic [5:0] CODE_TX    = 6'h02;
  localparam logic [5:0] CODE_MODEM = 6'h00;
  localparam logic [5:0] CODE_XCHAR = 6'h10;
  localparam logic [5:0] CODE_FLOW  = 6'h20;
  localparam logic [5:0] CODE_NONE  = 6'h01;

  // fifo trigger levels
  localparam logic [5:0] RX_TRIG_0 = 6'd8;
  localparam logic [5:0] RX_TRIG_1 = 6'd16;
  localparam logic [5:0] RX_TRIG_2 = 6'd24;
  localparam logic [5:0] RX_TRIG_3 = 6'd28;
  localparam logic [5:0] TX_TRIG_0 = 6'd16;
  localparam logic [5:0] TX_TRIG_1 = 6'd8;
  localparam logic [5:0] TX_TRIG_2 = 6'd24;
  localparam logic [5:0] TX_TRIG_3 = 6'd30;

  // receive time-out in bit times
  localparam int TMO_CHARS      = 4;
  localparam int TMO_CHAR_BITS  = 10;
  localparam int TMO_EXTRA_BITS = 12;
  localparam logic [6:0] TMO_BITS = 7'(TMO_CHARS * TMO_CHAR_BITS + TMO_EXTRA_BITS);

  // status from the fifo, line and flow engines of the channel
  typedef struct packed {
    logic [5:0] rx_level;
    logic       rx_push;
    logic       rx_push_err;
    logic       rx_pop;
    logic [2:0] top_err;
    logic       overrun;
    logic       fifo_err_any;
    logic [5:0] tx_level;
    logic       tx_shift_empty;
    logic [7:0] modem_bits;
    logic       delta_set;
    logic       xoff_det;
    logic       xon_det;
    logic       special_det;
    logic [1:0] flow_out;
    logic       wake;
  } chan_status_t;

  // host accesses to registers held outside this block
  typedef struct packed {
    logic rx_holding_read;
    logic tx_holding_write;
    logic global_first_read;
  } host_strobe_t;

endpackage

// ---- tb/irq_checker.sv ----
// port assertions for the channel interrupt block
`timescale 1ns/1ps
module irq_checker
  import uart_irq_pkg::*;
(
  input wire logic                       sys_clk_in,
  input wire logic                       rst_in,
  input wire logic                       psel_in,
  input wire logic                       penable_in,
  input wire logic                       pwrite_in,
  input wire logic [7:0]                 paddr_in,
  input wire logic [31:0]                pwdata_in,
  input wire logic [31:0]                prdata_out,
  input wire logic                       pready_out,
  input wire logic                       pslverr_out,
  input wire uart_irq_pkg::chan_status_t status_in,
  input wire uart_irq_pkg::host_strobe_t strobe_in,
  input wire logic                       irq_out,
  input wire logic [2:0]                 irq_level_out,
  input wire logic                       wake_out
);
  logic mask_line_reg;
  logic fifo_on_reg;
  logic wr_acc;
  assign wr_acc = psel_in && penable_in && pready_out && pwrite_in;

  // shadow copies, since the checker only sees the bus
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) mask_line_reg <= 1'b0;
    else if (wr_acc && paddr_in == MASK_OFS) mask_line_reg <= pwdata_in[MSK_LINE];
  end
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) fifo_on_reg <= 1'b0;
    else if (wr_acc && paddr_in == CONFIG_OFS) fifo_on_reg <= pwdata_in[CFG_FIFO_EN];
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  sequence setup_s; psel_in && !penable_in; endsequence
  sequence rd_cause_s; psel_in && !penable_in && !pwrite_in && paddr_in == CAUSE_OFS; endsequence

  ready_timing_a:
    assert property (setup_s |=> pready_out) else $error("ready late");
  ready_pulse_a:
    assert property (pready_out |=> !pready_out) else $error("ready held");
  unmapped_err_a:
    assert property (psel_in && penable_in && pready_out && paddr_in > CONFIG_OFS
      |-> pslverr_out && prdata_out == 32'h0) else $error("unmapped access accepted");
  cause_fifo_a:
    assert property (rd_cause_s |=> prdata_out[7:6] == {2{fifo_on_reg}})
      else $error("fifo bits wrong");
  line_err_irq_a:
    assert property (status_in.rx_push_err && mask_line_reg |-> ##[1:3]
      (irq_out && irq_level_out == 3'd1)) else $error("line error not raised");
  irq_level_a:
    assert property ((irq_level_out != 3'h0) == irq_out) else $error("request mismatch");
  idle_cause_a:
    assert property ((rd_cause_s and !irq_out) ##1 pready_out |-> prdata_out[5:0] == CODE_NONE)
      else $error("idle cause wrong");
  line_code_a:
    assert property ((rd_cause_s and irq_level_out == 3'd1) ##1 pready_out
      |-> prdata_out[5:0] == CODE_LINE)
      else $error("top cause wrong");
  wake_set_a:
    assert property (status_in.wake |-> ##[1:2] wake_out) else $error("wake missing");
  wake_clear_a:
    assert property (strobe_in.global_first_read && !status_in.wake |-> ##[1:2] !wake_out)
      else $error("wake stuck");
endmodule // irq_checker

bind uart_channel_irq irq_checker u_chk (.sys_clk_in, .rst_in, .psel_in, .penable_in,
  .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .status_in,
  .strobe_in, .irq_out, .irq_level_out, .wake_out);

// ---- tb/apb_host.sv ----
// apb host model reaching the channel registers
`timescale 1ns/1ps
module apb_host (
  input  wire logic        sys_clk_in,
  input  wire logic        pready_in,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pslverr_in,
  output logic             psel_out = 1'b0,
  output logic             penable_out = 1'b0,
  output logic             pwrite_out = 1'b0,
  output logic [7:0]       paddr_out = 8'h00,
  output logic [31:0]      pwdata_out = 32'h0
);
  // request held until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge sys_clk_in);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge sys_clk_in);
    penable_out <= 1'b1;
    // no wait-state count assumed; only the bench watchdog ends a stall
    do @(posedge sys_clk_in); while (pready_in !== 1'b1);
    q = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    // stale data must not look valid once released
    pwdata_out <= ~d;
  endtask
endmodule // apb_host

// ---- tb/testbench.sv ----
// self-checking bench for the channel interrupt block
`timescale 1ns/1ps
module testbench;
  import uart_irq_pkg::*;
  logic         sys_clk_in = 1'b0;
  logic         rst_in = 1'b1;
  logic         psel_in, penable_in, pwrite_in, pready_out, pslverr_out, irq_out, wake_out;
  logic         bit_tick_in, err, fo;
  logic [7:0]   paddr_in, v, ev;
  logic [31:0]  pwdata_in, prdata_out, rd;
  logic [2:0]   irq_level_out;
  logic [1:0]   flow_pin_in;
  chan_status_t st, status_in;
  host_strobe_t strobe_in;
  int           num_errors = 0;
  int           checked = 0;

  always #2.5 sys_clk_in = ~sys_clk_in;

  // event pulses: 0 push, 1 errored push, 2 delta, 3 xoff, 4 wake, 7:5 host strobes
  always_comb begin
    status_in = st;
    status_in.rx_push = ev[0];
    status_in.rx_push_err = ev[1];
    status_in.delta_set = ev[2];
    status_in.xoff_det = ev[3];
    status_in.wake = ev[4];
    strobe_in = host_strobe_t'(ev[7:5]);
  end

  apb_host u_host (.sys_clk_in, .pready_in(pready_out), .prdata_in(prdata_out),
    .pslverr_in(pslverr_out), .psel_out(psel_in), .penable_out(penable_in),
    .pwrite_out(pwrite_in), .paddr_out(paddr_in), .pwdata_out(pwdata_in));
  uart_channel_irq u_dut (.sys_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .bit_tick_in, .flow_pin_in,
    .status_in, .strobe_in, .irq_out, .irq_level_out, .wake_out);

  function automatic logic [31:0] cause_of(input logic f, input logic [5:0] code);
    return {24'h0, {2{f}}, code};
  endfunction
  function automatic logic [5:0] trig_of(input int sel);
    return (sel == 3) ? 6'd28 : 6'(8 * (sel + 1));
  endfunction

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge sys_clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, rd, err);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    u_host.xfer(1'b0, a, 32'h0, rd, err);
    chk_val(rd, exp);
  endtask
  task automatic cause(input logic [5:0] code);
    rdc(CAUSE_OFS, cause_of(fo, code));
  endtask
  task automatic fire(input int k);
    ev[k] <= 1'b1;
    @(posedge sys_clk_in);
    ev <= 8'h00;
    settle();
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      bit_tick_in <= 1'b1;
      @(posedge sys_clk_in);
      bit_tick_in <= 1'b0;
      @(posedge sys_clk_in);
    end
    settle();
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // a few hundred cycles are expected; twenty thousand means a hang
  initial begin
    #100000;
    num_errors++;
    final_report();
  end

  initial begin
    rd = 32'($urandom(24));
    st = '0;
    st.tx_shift_empty = 1'b1;
    ev = 8'h00;
    bit_tick_in = 1'b0;
    flow_pin_in = 2'b00;
    fo = 1'b0;
    repeat (5) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    cause(CODE_NONE);
    rdc(MASK_OFS, 32'(MASK_RST));
    rdc(LINE_OFS, 32'h60);
    u_host.xfer(1'b0, 8'h14, 32'h0, rd, err);
    chk_bit(err, 1'b1);
    wr(MASK_OFS, 32'hEF);
    rdc(MASK_OFS, 32'h0F);
    wr(CONFIG_OFS, 32'h400);
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom) & 8'hED;
      wr(MASK_OFS, 32'(v));
      rdc(MASK_OFS, 32'(v));
    end
    wr(MASK_OFS, 32'h01);
    st.rx_level <= 6'd1;
    fire(0);
    cause(CODE_RX);
    rdc(LINE_OFS, 32'h61);
    st.rx_level <= 6'd0;
    settle();
    cause(CODE_NONE);
    chk_bit(irq_out, 1'b0);
    fo = 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(CONFIG_OFS, 32'(32'h401 | (c << CFG_RX_TRIG)));
      st.rx_level <= trig_of(c) - 6'd1;
      settle();
      cause(CODE_NONE);
      st.rx_level <= trig_of(c) + 6'($urandom_range(3));
      settle();
      cause(CODE_RX);
      chk_val(32'(irq_level_out), 32'd2);
    end
    wr(CONFIG_OFS, 32'h401);
    wr(MASK_OFS, 32'h05);
    st.rx_level <= 6'd8;
    st.fifo_err_any <= 1'b1;
    fire(0);
    fire(1);
    cause(CODE_LINE);
    rdc(LINE_OFS, 32'hE1);
    cause(CODE_RX);
    st.top_err <= 3'b001;
    settle();
    cause(CODE_LINE);
    rdc(LINE_OFS, 32'hE5);
    st.top_err <= 3'b000;
    st.fifo_err_any <= 1'b0;
    st.rx_level <= 6'd0;
    settle();
    cause(CODE_NONE);
    rdc(LINE_OFS, 32'h60);
    st.tx_level <= 6'd20;
    st.tx_shift_empty <= 1'b0;
    fire(6);
    wr(MASK_OFS, 32'h02);
    for (int k = 0; k < 2; k++) begin
      wr(CONFIG_OFS, 32'(32'h401 | (k << CFG_RS485)));
      cause(CODE_NONE);
      st.tx_level <= 6'd10;
      settle();
      cause(CODE_TX);
      cause(CODE_NONE);
      st.tx_level <= 6'd0;
      settle();
      chk_bit(irq_out, k == 0);
      st.tx_shift_empty <= 1'b1;
      settle();
      chk_bit(irq_out, 1'b1);
      fire(6);
      chk_bit(irq_out, 1'b0);
      st.tx_level <= 6'd20;
      st.tx_shift_empty <= 1'b0;
      fire(6);
    end
    wr(CONFIG_OFS, 32'h401);
    wr(MASK_OFS, 32'h08);
    fire(2);
    cause(CODE_MODEM);
    chk_val(32'(irq_level_out), 32'd5);
    u_host.xfer(1'b0, MODEM_OFS, 32'h0, rd, err);
    cause(CODE_NONE);
    wr(MASK_OFS, 32'h00);
    fire(3);
    cause(CODE_NONE);
    wr(MASK_OFS, 32'h20);
    fire(3);
    cause(CODE_XCHAR);
    cause(CODE_NONE);
    fire(4);
    chk_bit(wake_out, 1'b1);
    cause(CODE_NONE);
    fire(5);
    chk_bit(wake_out, 1'b0);
    wr(MASK_OFS, 32'h01);
    st.rx_level <= 6'd1;
    fire(0);
    ticks(4 * TMO_CHAR_BITS + 12 - 2);
    cause(CODE_NONE);
    ticks(4);
    cause(CODE_TMO);
    fire(7);
    cause(CODE_NONE);
    wr(CONFIG_OFS, 32'h1401);
    wr(MASK_OFS, 32'h80);
    flow_pin_in <= 2'b01;
    repeat (8) @(posedge sys_clk_in);
    cause(CODE_FLOW);
    chk_val(32'(irq_level_out), 32'd7);
    u_host.xfer(1'b0, MODEM_OFS, 32'h0, rd, err);
    cause(CODE_NONE);
    wr(MASK_OFS, 32'h00);
    st.tx_level <= 6'd0;
    st.tx_shift_empty <= 1'b1;
    fire(0);
    chk_bit(irq_out, 1'b0);
    rdc(LINE_OFS, 32'h61);
    final_report();
  end
endmodule // testbench
